/* File: scc_defs.vh */
// register map, field positions, reset values and command codes
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// register indices as printed; byte address is four times the index
`define SCC_IDX_PEND_ADDR 8'h00
`define SCC_IDX_CHAN_EN 8'h01
`define SCC_IDX_EMIT_12 8'h02
`define SCC_IDX_EMIT_3 8'h03
`define SCC_IDX_PROX_ALIGN 8'h05
`define SCC_IDX_AMB_ALIGN 8'h06

// block-specific registers
`define SCC_ADDR_CMD 8'h20
`define SCC_ADDR_STATUS 8'h24
`define SCC_ADDR_ACT_ADDR 8'h28
`define SCC_ADDR_RES_BASE 8'h40
`define SCC_ADDR_RES_LAST 8'h54

// reset values
`define SCC_RST_PEND_ADDR 8'h00
`define SCC_RST_CHAN_EN 8'h00
`define SCC_RST_EMIT_12 8'h21
`define SCC_RST_EMIT_3 8'h04
`define SCC_RST_PROX_ALIGN 8'h00
`define SCC_RST_AMB_ALIGN 8'h00
`define SCC_RST_ACT_ADDR 8'h00

// writable bit masks
`define SCC_MSK_CHAN_EN 8'h77
`define SCC_MSK_EMIT_12 8'h77
`define SCC_MSK_EMIT_3 8'h07
`define SCC_MSK_PROX_ALIGN 8'h70
`define SCC_MSK_AMB_ALIGN 8'h30

// field positions
`define SCC_BIT_AUX_ON 6
`define SCC_BIT_IR_ON 5
`define SCC_BIT_VIS_ON 4
`define SCC_BIT_P3_ON 2
`define SCC_BIT_P2_ON 1
`define SCC_BIT_P1_ON 0
`define SCC_LSB_P1_EMIT 0
`define SCC_LSB_P2_EMIT 4
`define SCC_LSB_P3_EMIT 0
`define SCC_BIT_P1_LOW 4
`define SCC_BIT_P2_LOW 5
`define SCC_BIT_P3_LOW 6
`define SCC_BIT_VIS_LOW 4
`define SCC_BIT_IR_LOW 5

// command codes written to the command register
`define SCC_CMD_ADDR_CHANGE 8'h01
`define SCC_CMD_FORCE 8'h02

// channel numbers in sequence order
`define SCC_CH_P1 3'h0
`define SCC_CH_P2 3'h1
`define SCC_CH_P3 3'h2
`define SCC_CH_VIS 3'h3
`define SCC_CH_IR 3'h4
`define SCC_CH_AUX 3'h5

// AHB encodings
`define SCC_HTRANS_NONSEQ 2'h2
`define SCC_HTRANS_SEQ 2'h3

`endif

/* File: scc_result_mem.v */
// result store: one 16-bit word per channel, registered read
module scc_result_mem (
  // clock
  input wire clock,
  // write port
  input wire wr_en,
  input wire [2:0] wr_addr,
  input wire [15:0] wr_data,
  // read port
  input wire [2:0] rd_addr,
  output reg [15:0] rd_data
);

  reg [15:0] mem [0:7];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // scc_result_mem

/* File: scc_params.v */
// configuration registers and measurement sequencer with AHB-Lite slave
`include "scc_defs.vh"

// Function
// - pending address applies only on change command
// - bit 6 runs aux channel into aux result
// - bit 5 runs ambient infrared channel
// - bit 4 runs ambient visible channel
// - bits 2..0 run proximity three, two, one
// - proximity one emitters from bits 2:0
// - emitter bits act independently, any combination
// - proximity two emitters bits 6:4, reset 0x21
// - proximity three emitters bits 2:0, reset 0x04
// - proximity alignment bits 6..4 pick low/high
// - ambient bit 5 picks infrared result alignment
// - ambient bit 4 picks visible result alignment
module scc_params (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // converter
  output reg conv_start_q,
  output reg [2:0] conv_sel_q,
  input wire conv_done,
  input wire [16:0] conv_value,
  // emitter drives
  output reg emitter_one_q,
  output reg emitter_two_q,
  output reg emitter_three_q,
  // bus address in use
  output reg [7:0] bus_address_q,
  // sequencer state
  output wire busy
);

  localparam ST_IDLE = 3'h0;
  localparam ST_PICK = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_STORE = 3'h4;

  // configuration
  reg [7:0] pend_addr_q;
  reg [7:0] chan_list_q;
  reg [7:0] emit_12_q;
  reg [7:0] emit_3_q;
  reg [7:0] prox_align_q;
  reg [7:0] amb_align_q;

  // bus data phase
  reg wr_pend_q;
  reg rd_pend_q;
  reg [7:0] addr_q;

  // sequencer
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] chan_q;
  reg [15:0] result_q;
  reg force_q;

  wire [15:0] mem_rd_data;
  wire take;
  wire [2:0] rd_slot;

  // channel enable bit for a sequence slot
  function chan_on;
    input [7:0] list;
    input [2:0] ch;
    begin
      case (ch)
        `SCC_CH_P1: chan_on = list[`SCC_BIT_P1_ON];
        `SCC_CH_P2: chan_on = list[`SCC_BIT_P2_ON];
        `SCC_CH_P3: chan_on = list[`SCC_BIT_P3_ON];
        `SCC_CH_VIS: chan_on = list[`SCC_BIT_VIS_ON];
        `SCC_CH_IR: chan_on = list[`SCC_BIT_IR_ON];
        `SCC_CH_AUX: chan_on = list[`SCC_BIT_AUX_ON];
        default: chan_on = 1'b0;
      endcase
    end
  endfunction

  // low-bits choice for a sequence slot; aux always reports upper bits
  function low_pick;
    input [7:0] pa;
    input [7:0] aa;
    input [2:0] ch;
    begin
      case (ch)
        `SCC_CH_P1: low_pick = pa[`SCC_BIT_P1_LOW];
        `SCC_CH_P2: low_pick = pa[`SCC_BIT_P2_LOW];
        `SCC_CH_P3: low_pick = pa[`SCC_BIT_P3_LOW];
        `SCC_CH_VIS: low_pick = aa[`SCC_BIT_VIS_LOW];
        `SCC_CH_IR: low_pick = aa[`SCC_BIT_IR_LOW];
        default: low_pick = 1'b0;
      endcase
    end
  endfunction

  // emitter set for a slot; bit n drives emitter n+1, independently
  function [2:0] emit_pick;
    input [7:0] e12;
    input [7:0] e3;
    input [2:0] ch;
    begin
      case (ch)
        `SCC_CH_P1: emit_pick = e12[`SCC_LSB_P1_EMIT +: 3];
        `SCC_CH_P2: emit_pick = e12[`SCC_LSB_P2_EMIT +: 3];
        `SCC_CH_P3: emit_pick = e3[`SCC_LSB_P3_EMIT +: 3];
        default: emit_pick = 3'h0;
      endcase
    end
  endfunction

  // byte address of a register index; one word per register
  function [7:0] word_at;
    input [7:0] idx;
    begin
      word_at = {idx[5:0], 2'b00};
    end
  endfunction

  // result window: word-aligned addresses from first to last slot
  function in_results;
    input [7:0] a;
    begin
      in_results = (a >= `SCC_ADDR_RES_BASE) &&
        (a <= `SCC_ADDR_RES_LAST) && (a[1:0] == 2'b00);
    end
  endfunction

  // next slot in sequence order; aux is the last slot
  function [2:0] next_slot;
    input [2:0] ch;
    begin
      next_slot = ch + 3'h1;
    end
  endfunction

  // 16 of the 17 converter bits: low bits when set, upper when clear
  function [15:0] align16;
    input [16:0] v;
    input low;
    begin
      if (low) begin
        align16 = v[15:0];
      end else begin
        align16 = v[16:1];
      end
    end
  endfunction

  // address phase is taken on hready with a live transfer
  assign take = hsel & hready &
    (htrans == `SCC_HTRANS_NONSEQ | htrans == `SCC_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = (state_q != ST_IDLE);
  assign rd_slot = haddr[4:2];

  // address phase held for the data phase that follows
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // register writes in the data phase
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_addr_q <= `SCC_RST_PEND_ADDR;
      chan_list_q <= `SCC_RST_CHAN_EN;
      emit_12_q <= `SCC_RST_EMIT_12;
      emit_3_q <= `SCC_RST_EMIT_3;
      prox_align_q <= `SCC_RST_PROX_ALIGN;
      amb_align_q <= `SCC_RST_AMB_ALIGN;
      bus_address_q <= `SCC_RST_ACT_ADDR;
      force_q <= 1'b0;
    end else begin
      force_q <= 1'b0;
      if (wr_pend_q) begin
        case (addr_q)
          word_at(`SCC_IDX_PEND_ADDR): pend_addr_q <= hwdata[7:0];
          word_at(`SCC_IDX_CHAN_EN):
            chan_list_q <= hwdata[7:0] & `SCC_MSK_CHAN_EN;
          word_at(`SCC_IDX_EMIT_12):
            emit_12_q <= hwdata[7:0] & `SCC_MSK_EMIT_12;
          word_at(`SCC_IDX_EMIT_3):
            emit_3_q <= hwdata[7:0] & `SCC_MSK_EMIT_3;
          word_at(`SCC_IDX_PROX_ALIGN):
            prox_align_q <= hwdata[7:0] & `SCC_MSK_PROX_ALIGN;
          word_at(`SCC_IDX_AMB_ALIGN):
            amb_align_q <= hwdata[7:0] & `SCC_MSK_AMB_ALIGN;
          `SCC_ADDR_CMD: begin
            if (hwdata[7:0] == `SCC_CMD_ADDR_CHANGE) begin
              bus_address_q <= pend_addr_q;
            end
            if (hwdata[7:0] == `SCC_CMD_FORCE) begin
              force_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; results come from the memory's registered output
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (rd_pend_q) begin
      case (addr_q)
        word_at(`SCC_IDX_PEND_ADDR): rd_mux[7:0] = pend_addr_q;
        word_at(`SCC_IDX_CHAN_EN): rd_mux[7:0] = chan_list_q;
        word_at(`SCC_IDX_EMIT_12): rd_mux[7:0] = emit_12_q;
        word_at(`SCC_IDX_EMIT_3): rd_mux[7:0] = emit_3_q;
        word_at(`SCC_IDX_PROX_ALIGN): rd_mux[7:0] = prox_align_q;
        word_at(`SCC_IDX_AMB_ALIGN): rd_mux[7:0] = amb_align_q;
        `SCC_ADDR_STATUS: rd_mux[3:0] = {busy, chan_q};
        `SCC_ADDR_ACT_ADDR: rd_mux[7:0] = bus_address_q;
        default: begin
          if (in_results(addr_q)) begin
            rd_mux[15:0] = mem_rd_data;
          end
        end
      endcase
    end
  end
  assign hrdata = rd_mux;

  // sequencer next state
  // a force that arrives mid-sequence is dropped, not queued
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (force_q) begin
          state_d = ST_PICK;
        end
      end
      ST_PICK: begin
        if (chan_on(chan_list_q, chan_q)) begin
          state_d = ST_START;
        end else if (chan_q == `SCC_CH_AUX) begin
          state_d = ST_IDLE;
        end
      end
      ST_START: state_d = ST_WAIT;
      ST_WAIT: begin
        if (conv_done) begin
          state_d = ST_STORE;
        end
      end
      ST_STORE: begin
        if (chan_q == `SCC_CH_AUX) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_PICK;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // sequencer registers; emitters light with the start pulse and go
  // dark on the edge that sees done, so they frame one conversion only
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      chan_q <= `SCC_CH_P1;
      result_q <= 16'h0000;
      conv_start_q <= 1'b0;
      conv_sel_q <= 3'h0;
      emitter_one_q <= 1'b0;
      emitter_two_q <= 1'b0;
      emitter_three_q <= 1'b0;
    end else begin
      state_q <= state_d;
      conv_start_q <= (state_q == ST_PICK) &
        chan_on(chan_list_q, chan_q);
      case (state_q)
        ST_IDLE: chan_q <= `SCC_CH_P1;
        ST_PICK: begin
          if (chan_on(chan_list_q, chan_q)) begin
            conv_sel_q <= chan_q;
            {emitter_three_q, emitter_two_q, emitter_one_q} <=
              emit_pick(emit_12_q, emit_3_q, chan_q);
          end else if (chan_q != `SCC_CH_AUX) begin
            chan_q <= next_slot(chan_q);
          end
        end
        ST_WAIT: begin
          if (conv_done) begin
            {emitter_three_q, emitter_two_q, emitter_one_q} <= 3'h0;
            result_q <= align16(conv_value,
              low_pick(prox_align_q, amb_align_q, chan_q));
          end
        end
        ST_STORE: begin
          if (chan_q != `SCC_CH_AUX) begin
            chan_q <= next_slot(chan_q);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // only an enabled slot reaches the store state
  scc_result_mem u_mem (
    .clock(clock),
    .wr_en(state_q == ST_STORE),
    .wr_addr(chan_q),
    .wr_data(result_q),
    .rd_addr(rd_slot),
    .rd_data(mem_rd_data)
  );

endmodule // scc_params

/* File: scc_params_properties.sv */
// port-level assertions for the configuration and sequencer block
module scc_params_props (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // converter, emitters, address
  input wire conv_start_q,
  input wire conv_done,
  input wire emitter_one_q,
  input wire emitter_two_q,
  input wire emitter_three_q,
  input wire [7:0] bus_address_q,
  input wire busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire cmd_w = hsel && htrans[1] && hwrite && haddr == 8'h20;
  wire rd_t = hsel && htrans[1] && !hwrite;
  wire [2:0] em = {emitter_three_q, emitter_two_q, emitter_one_q};
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  AST_ADDR_ON_CMD: assert property (
    $changed(bus_address_q) |-> $past(cmd_w, 2))
    else $error("bus address moved without command");
  AST_START_PULSE: assert property (
    conv_start_q |=> !conv_start_q [*3])
    else $error("conversion start too long or too soon");
  AST_START_IN_SEQ: assert property (conv_start_q |-> busy)
    else $error("conversion started outside a sequence");
  AST_EMIT_OFF_DONE: assert property (
    conv_done && busy && !conv_start_q |=> em == 3'h0)
    else $error("emitters still on after conversion");
  AST_EMIT_IDLE: assert property (!busy |-> em == 3'h0)
    else $error("emitter on while idle");
  AST_EMIT_HOLD: assert property (
    em != 3'h0 && !conv_done |=> $stable(em))
    else $error("emitters changed during conversion");
  AST_RD_PHASE: assert property (hrdata != 32'h0 |-> $past(rd_t))
    else $error("read data outside data phase");
  AST_BUSY_CAUSE: assert property (
    $rose(busy) |-> $past(cmd_w, 2) || $past(cmd_w, 3))
    else $error("sequence began without command");
  cover property (conv_start_q && em == 3'h7);
  cover property ($changed(bus_address_q));
  cover property ($fell(busy));
endmodule // scc_params_props

bind scc_params scc_params_props props (.clock(clock), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .conv_start_q(conv_start_q), .conv_done(conv_done),
  .emitter_one_q(emitter_one_q), .emitter_two_q(emitter_two_q),
  .emitter_three_q(emitter_three_q), .bus_address_q(bus_address_q),
  .busy(busy));

/* File: scc_conv_model.sv */
// converter stand-in: answers each start after a random delay
module scc_conv_model (
  // clock
  input wire clock,
  // converter link
  input wire conv_start_q,
  output logic conv_done,
  output logic [16:0] conv_value
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    conv_done = 1'b0;
    conv_value = 17'h0;
    forever begin
      @(posedge clock);
      if (conv_start_q === 1'b1) begin
        repeat ($urandom_range(4, 1)) @(posedge clock);
        conv_value <= 17'($urandom);
        conv_done <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
        // no stale value once done drops
        conv_value <= ~conv_value;
      end
    end
  end
endmodule // scc_conv_model

/* File: scc_params_test.sv */
// self-checking bench for the configuration and sequencer block
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module scc_params_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_b, hsel, hwrite;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, rd, w;
  wire [31:0] hrdata;
  wire hreadyout, hresp, conv_start_q, busy, e1, e2, e3, conv_done;
  wire [2:0] conv_sel_q;
  wire [7:0] bus_address_q;
  wire [16:0] conv_value;
  logic [7:0] msk [8] = '{8'hFF, 8'h77, 8'h77, 8'h07, 8'h00, 8'h70, 8'h30,
    8'h00};
  logic [7:0] m [8] = '{8'h00, 8'h00, 8'h21, 8'h04, 8'h00, 8'h00, 8'h00,
    8'h00};
  logic [15:0] mr [6];
  bit ok [6];
  int q [$];
  int n_fail, num_checks, cyc, cur;
  scc_params dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_start_q(conv_start_q), .conv_sel_q(conv_sel_q),
    .conv_done(conv_done), .conv_value(conv_value), .emitter_one_q(e1),
    .emitter_two_q(e2), .emitter_three_q(e3),
    .bus_address_q(bus_address_q), .busy(busy));
  scc_conv_model conv (.clock(clock), .conv_start_q(conv_start_q),
    .conv_done(conv_done), .conv_value(conv_value));
  function automatic logic [2:0] emit(int s);
    return s == 0 ? m[2][2:0] : s == 1 ? m[2][6:4] : s == 2 ? m[3][2:0] : 3'h0;
  endfunction
  function automatic bit low(int s);
    return s < 3 ? m[5][4 + s] : s < 5 ? m[6][s + 1] : 1'b0;
  endfunction
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task xfer(input [7:0] a, input bit wr, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK("rdata", e, rd)
  endtask
  task meas(input [7:0] l);
    int t;
    xfer(8'h04, 1'b1, {24'h0, l});
    m[1] = l & msk[1];
    for (int s = 0; s < 6; s++) if (m[1][s < 3 ? s : s + 1]) q.push_back(s);
    xfer(8'h20, 1'b1, 32'h2);
    repeat (3) @(posedge clock);
    for (t = 0; t < 300 && busy !== 1'b0; t++) @(posedge clock);
    `CHK("idle", 1'b0, busy)
    `CHK("left", 0, q.size())
    for (int s = 0; s < 6; s++) begin
      if (ok[s]) rchk(8'(8'h40 + 4 * s), {16'h0, mr[s]});
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // cycle budget; running out counts as a failure
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  // converter-side monitor and model of stored results
  always @(posedge clock) begin
    if (conv_start_q === 1'b1) begin
      cur = q.size() ? q.pop_front() : 7;
      `CHK("slot", 3'(cur), conv_sel_q)
      `CHK("emit", emit(cur), {e3, e2, e1})
    end
    if (conv_done === 1'b1 && cur < 6) begin
      mr[cur] = low(cur) ? conv_value[15:0] : conv_value[16:1];
      ok[cur] = 1'b1;
    end
  end
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    void'($urandom(32));
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(8'(4 * i), {24'h0, m[i]});
    rchk(8'h28, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      xfer(8'(4 * i), 1'b1, w);
      m[i] = w[7:0] & msk[i];
      rchk(8'(4 * i), {24'h0, m[i]});
    end
    $display("test register access done");
    xfer(8'h00, 1'b1, 32'h5A);
    `CHK("addr", 8'h00, bus_address_q)
    xfer(8'h20, 1'b1, 32'h1);
    @(posedge clock);
    `CHK("addr", 8'h5A, bus_address_q)
    rchk(8'h28, 32'h5A);
    $display("test address change done");
    for (int k = 0; k < 12; k++) begin
      for (int i = 2; i < 7; i++) begin
        w = $urandom;
        // all three emitters fitted, so every select bit is legal
        if (i != 4) xfer(8'(4 * i), 1'b1, w);
        if (i != 4) m[i] = w[7:0] & msk[i];
      end
      w = $urandom_range(63, 1);
      // never an empty list: any non-zero mix of the six channel bits
      meas(k == 0 ? 8'h77 : {1'b0, w[5:3], 1'b0, w[2:0]});
    end
    $display("test measurement done");
    give_verdict();
  end
endmodule // scc_params_test
